//--- logic/mse_engine.sv
// Purpose: macro service engine with request acceptance timing
// Assumes: memory/peripheral port answers with a one-cycle acc_ack
// Notes:   channel fields sit below the channel pointer in page FE
module mse_engine
   import mse_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // request sources and cpu sequencing
   input wire logic [15:0] irq_req,
   input wire logic insn_end,
   input wire logic defer_event,
   input wire logic long_insn,
   input wire logic [15:0] sp_val,
   input wire logic [15:0] psw_val,
   output logic cpu_hold,
   output logic suspend_req,
   output logic psw_we,
   output logic [15:0] psw_wdata,
   // vectored acceptance
   output logic vec_ack,
   output logic [3:0] vec_src,
   output logic vec_busy,
   // memory and peripheral register port
   output mse_acc_s acc,
   input wire logic acc_ack,
   input wire logic [15:0] acc_rdata
);

   // ==========================================================
   // helpers
   function automatic logic [3:0] first_set(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--)
         if (v[i])
            r = 4'(i);
      return r;
   endfunction

   // ==========================================================
   // apb register file
   mse_ctrl_s ctrl_reg;
   logic [15:0] mask_reg, msel_reg, result_reg;
   logic [31:0] prdata_reg, rd_mux;
   logic [15:0] ms_pend_reg, vec_pend_reg;
   logic fault_reg, unsup_reg, susp_reg;
   logic [3:0] src_reg;
   mse_state_e state_reg, state_next;

   wire logic hit_ctrl = paddr == OFS_CTRL;
   wire logic hit_mask = paddr == OFS_MASK;
   wire logic hit_msel = paddr == OFS_MSEL;
   wire logic hit_any = hit_ctrl | hit_mask | hit_msel |
      (paddr == OFS_STAT) | (paddr == OFS_PEND) | (paddr == OFS_RES);
   wire logic apb_wr = psel & penable & pwrite & hit_any;
   wire logic ms_busy = state_reg != ST_IDLE;

   assign rd_mux = hit_ctrl ? {22'h0, ctrl_reg} :
      hit_mask ? {16'h0, mask_reg} :
      hit_msel ? {16'h0, msel_reg} :
      (paddr == OFS_STAT) ? {24'h0, ms_busy, vec_busy, fault_reg,
                             unsup_reg, src_reg} :
      (paddr == OFS_PEND) ? {vec_pend_reg, ms_pend_reg} :
      (paddr == OFS_RES) ? {16'h0, result_reg} : 32'h0;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prdata_reg <= 32'h0;
      else if (psel & ~penable)
         prdata_reg <= rd_mux;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl_reg <= '0;
         mask_reg <= MASK_RST;
         msel_reg <= MSEL_RST;
      end
      else if (apb_wr)
      begin
         if (hit_ctrl)
            ctrl_reg <= pwdata[9:0];
         if (hit_mask)
            mask_reg <= pwdata[15:0];
         if (hit_msel)
            msel_reg <= pwdata[15:0];
      end

   // ==========================================================
   // request flags, priority and deferral timing
   logic [3:0] prio_cnt_reg, defer_cnt_reg;
   logic skip_reg, vec_ack_reg;
   logic [3:0] vec_src_reg;
   logic [7:0] vec_cnt_reg, vec_time;
   logic cnt_zero_set;

   wire logic [15:0] ms_cand = ms_pend_reg & ~mask_reg;
   wire logic [15:0] vec_cand = vec_pend_reg & ~mask_reg;
   wire logic boundary = (insn_end & ~skip_reg) | long_insn;
   wire logic eligible = ctrl_reg.enable & (prio_cnt_reg == 4'h0) &
      (defer_cnt_reg == 4'h0) & ~ms_busy & ~vec_busy & boundary;
   wire logic ms_start = eligible & (|ms_cand);
   wire logic vec_start = eligible & ~(|ms_cand) & (|vec_cand);
   wire logic [3:0] grant_src = ms_start ? first_set(ms_cand) :
      first_set(vec_cand);
   wire logic [15:0] grant_bit = 16'h0001 << grant_src;
   wire logic [15:0] zero_bit = cnt_zero_set ? (16'h0001 << src_reg) :
      16'h0000;

   // arriving flags win over the clear of the acknowledge
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ms_pend_reg <= 16'h0;
         vec_pend_reg <= 16'h0;
      end
      else
      begin
         ms_pend_reg <= (ms_pend_reg & ~(ms_start ? grant_bit : 16'h0)) |
            (irq_req & msel_reg);
         vec_pend_reg <= (vec_pend_reg & ~(vec_start ? grant_bit : 16'h0))
            | (irq_req & ~msel_reg) | zero_bit;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prio_cnt_reg <= 4'h0;
      else if ((|irq_req) | cnt_zero_set)
         prio_cnt_reg <= PRIO_CLKS;
      else if (prio_cnt_reg != 4'h0)
         prio_cnt_reg <= prio_cnt_reg - 4'h1;

   // defer_event comes from the cpu decode of any deferring instruction
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         defer_cnt_reg <= 4'h0;
         skip_reg <= 1'b0;
      end
      else
      begin
         if (defer_event)
            defer_cnt_reg <= DEFER_CLKS;
         else if (defer_cnt_reg != 4'h0)
            defer_cnt_reg <= defer_cnt_reg - 4'h1;
         if (defer_event)
            skip_reg <= 1'b1;
         else if (insn_end)
            skip_reg <= 1'b0;
      end

   // vectored acceptance time by stack placement
   always_comb
   begin
      vec_time = T_VEC_FAST;
      unique case (ctrl_reg.stack_area)
         AREA_FAST: vec_time = T_VEC_FAST;
         AREA_PERIPHERAL_RAM: vec_time = T_VEC_PERIPHERAL_RAM + (sp_val[0] ? T_SP_ODD : 8'h0);
         AREA_WIDE: vec_time = T_VEC_WIDE + {3'h0, ctrl_reg.wait_n, 1'b0};
         AREA_NARROW: vec_time = T_VEC_NARROW + {2'h0, ctrl_reg.wait_n,
                                                 2'h0};
      endcase
      if (ctrl_reg.ctx_switch)
         vec_time = T_CTX;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         vec_cnt_reg <= 8'h0;
         vec_ack_reg <= 1'b0;
         vec_src_reg <= 4'h0;
      end
      else
      begin
         vec_ack_reg <= vec_start;
         if (vec_start)
         begin
            vec_cnt_reg <= vec_time;
            vec_src_reg <= grant_src;
         end
         else if (vec_cnt_reg != 8'h0)
            vec_cnt_reg <= vec_cnt_reg - 8'h1;
      end

   assign vec_busy = vec_cnt_reg != 8'h0;
   assign vec_ack = vec_ack_reg;
   assign vec_src = vec_src_reg;
   assign cpu_hold = ms_busy;
   // a suspended block instruction resumes once service is over
   assign suspend_req = (ms_start | vec_start) & long_insn;

   // ==========================================================
   // service sequencer
   logic [7:0] mode_reg, chp_reg, msc_reg, sfr_reg, svc_cnt_reg;
   logic [7:0] svc_target;
   logic [15:0] prev_reg, cur_reg, mptr_reg, sp_start_reg;
   mse_acc_s acc_reg, acc_next;
   logic psw_we_reg;
   logic [15:0] psw_wdata_reg;

   wire logic acc_done = acc_reg.valid & acc_ack;
   wire logic is_dif = mode_reg == MODE_DIF;
   wire logic is_difp = mode_reg == MODE_DIFP;
   wire logic is_full = mode_reg == MODE_CHK_FULL;
   wire logic [7:0] cw_mode = acc_rdata[7:0];
   wire logic mode_ok = (cw_mode == MODE_DIF) | (cw_mode == MODE_DIFP) |
      (cw_mode == MODE_CHK_FULL) | (cw_mode == MODE_CHK_RED);
   wire logic [15:0] ch_base = {CH_PAGE, chp_reg};
   wire logic [15:0] msc2 = {7'h0, msc_reg, 1'b0};
   wire logic [15:0] dif_addr = ch_base - msc2 - DIF_BUF_OFS;
   wire logic [15:0] difp_addr = mptr_reg - msc2 + DIFP_BUF_OFS;
   wire logic [15:0] chk_sub = is_full ? CHK_FULL_SUB : CHK_RED_SUB;
   wire logic chk_ok = ~fault_reg & (sp_val == sp_start_reg);
   wire logic [15:0] chk_good = prev_reg - chk_sub;
   wire logic [15:0] chk_val = chk_ok ? chk_good : ~chk_good;
   wire logic acc_state = (state_reg != ST_IDLE) & (state_reg != ST_PSW) &
      (state_reg != ST_PSWCHK) & (state_reg != ST_PAD);

   always_comb
   begin
      acc_next = '0;
      acc_next.valid = acc_state;
      unique case (state_reg)
         ST_CW: acc_next.addr = CW_BASE + {11'h0, src_reg, 1'b0};
         ST_CH: acc_next.addr = ch_base - CH_OFS_CNT;
         ST_PREV: acc_next.addr = ch_base - CH_OFS_PREV;
         ST_MPTR: acc_next.addr = ch_base - CH_OFS_MPTR;
         ST_SFR:
         begin
            acc_next.periph = 1'b1;
            acc_next.addr = {SFR_PAGE, sfr_reg};
         end
         ST_BUF:
         begin
            acc_next.we = 1'b1;
            acc_next.addr = is_difp ? difp_addr : dif_addr;
            acc_next.wdata = cur_reg - prev_reg;
         end
         ST_SAVE:
         begin
            acc_next.we = 1'b1;
            acc_next.addr = ch_base - CH_OFS_PREV;
            acc_next.wdata = cur_reg;
         end
         ST_CNT:
         begin
            acc_next.we = 1'b1;
            acc_next.addr = ch_base - CH_OFS_CNT;
            acc_next.wdata = {sfr_reg, msc_reg - 8'h1};
         end
         ST_RAMWR:
         begin
            acc_next.we = 1'b1;
            acc_next.addr = ch_base - CH_OFS_PREV;
            acc_next.wdata = ~prev_reg;
         end
         ST_RAMRD: acc_next.addr = ch_base - CH_OFS_PREV;
         ST_RAMRST:
         begin
            acc_next.we = 1'b1;
            acc_next.addr = ch_base - CH_OFS_PREV;
            acc_next.wdata = prev_reg;
         end
         ST_RES:
         begin
            acc_next.we = 1'b1;
            acc_next.periph = 1'b1;
            acc_next.addr = {SFR_PAGE, sfr_reg};
            acc_next.wdata = chk_val;
         end
         default: acc_next.valid = 1'b0;
      endcase
   end

   // service length including data-area penalties
   always_comb
   begin
      svc_target = T_CHK_RED;
      if (is_full)
         svc_target = T_CHK_FULL;
      else if (is_dif)
         svc_target = T_DIF;
      else if (is_difp)
      begin
         svc_target = T_DIFP;
         unique case (ctrl_reg.data_area)
            AREA_FAST: svc_target = T_DIFP;
            AREA_PERIPHERAL_RAM: svc_target = T_DIFP_SLOW +
               (mptr_reg[0] ? T_ODD_WORD : 8'h0);
            AREA_WIDE: svc_target = T_DIFP_SLOW + (mptr_reg[0] ?
               T_NARROW_WORD + {3'h0, ctrl_reg.wait_n, 1'b0} :
               {4'h0, ctrl_reg.wait_n});
            AREA_NARROW: svc_target = T_DIFP_SLOW + T_NARROW_WORD +
               {3'h0, ctrl_reg.wait_n, 1'b0};
         endcase
      end
   end

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (ms_start) state_next = ST_CW;
         ST_CW: if (acc_done) state_next = mode_ok ? ST_CH : ST_PAD;
         ST_CH: if (acc_done) state_next = ST_PREV;
         ST_PREV:
            if (acc_done)
               state_next = is_difp ? ST_MPTR : is_dif ? ST_SFR :
                  is_full ? ST_PSW : ST_RAMWR;
         ST_MPTR: if (acc_done) state_next = ST_SFR;
         ST_SFR: if (acc_done) state_next = ST_BUF;
         ST_BUF: if (acc_done) state_next = ST_SAVE;
         ST_SAVE: if (acc_done) state_next = ST_CNT;
         ST_CNT: if (acc_done) state_next = ST_PAD;
         ST_PSW: state_next = ST_PSWCHK;
         ST_PSWCHK: state_next = ST_RAMWR;
         ST_RAMWR: if (acc_done) state_next = ST_RAMRD;
         ST_RAMRD: if (acc_done) state_next = ST_RAMRST;
         ST_RAMRST: if (acc_done) state_next = ST_RES;
         ST_RES: if (acc_done) state_next = ST_PAD;
         ST_PAD:
            if (unsup_reg | (svc_cnt_reg + 8'h1 >= svc_target))
               state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   assign cnt_zero_set = (state_reg == ST_CNT) & acc_done &
      (msc_reg == 8'h1);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         acc_reg <= '0;
         svc_cnt_reg <= 8'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (acc_done)
            acc_reg <= '0;
         else if (~acc_reg.valid)
            acc_reg <= acc_next;
         svc_cnt_reg <= ms_start ? 8'h0 : svc_cnt_reg + {7'h0, ms_busy};
      end

   // captured channel fields
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mode_reg <= 8'h0;
         chp_reg <= 8'h0;
         msc_reg <= 8'h0;
         sfr_reg <= 8'h0;
         prev_reg <= 16'h0;
         mptr_reg <= 16'h0;
         cur_reg <= 16'h0;
      end
      else if (acc_done)
         unique case (state_reg)
            ST_CW: {chp_reg, mode_reg} <= acc_rdata;
            ST_CH: {sfr_reg, msc_reg} <= acc_rdata;
            ST_PREV: prev_reg <= acc_rdata;
            ST_MPTR: mptr_reg <= acc_rdata;
            ST_SFR: cur_reg <= acc_rdata;
            default: ;
         endcase

   // status, check fault and status word exercise
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         src_reg <= 4'h0;
         fault_reg <= 1'b0;
         unsup_reg <= 1'b0;
         susp_reg <= 1'b0;
         sp_start_reg <= 16'h0;
         result_reg <= 16'h0;
      end
      else
      begin
         if (ms_start)
         begin
            src_reg <= grant_src;
            fault_reg <= 1'b0;
            unsup_reg <= 1'b0;
            sp_start_reg <= sp_val;
         end
         if ((state_reg == ST_CW) & acc_done & ~mode_ok)
            unsup_reg <= 1'b1;
         if ((state_reg == ST_PSWCHK) & (psw_val != PSW_PAT))
            fault_reg <= 1'b1;
         if ((state_reg == ST_RAMRD) & acc_done & (acc_rdata != ~prev_reg))
            fault_reg <= 1'b1;
         if (acc_done & acc_reg.we & acc_reg.periph)
            result_reg <= acc_reg.wdata;
         if (suspend_req)
            susp_reg <= 1'b1;
         else if (~ms_busy & ~vec_busy)
            susp_reg <= 1'b0;
      end

   // pattern first, then zero: the full check leaves the word cleared
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         psw_we_reg <= 1'b0;
         psw_wdata_reg <= 16'h0;
      end
      else
      begin
         psw_we_reg <= (state_next == ST_PSW) | (state_next == ST_PSWCHK);
         psw_wdata_reg <= (state_next == ST_PSW) ? PSW_PAT : 16'h0;
      end

   assign acc = acc_reg;
   assign psw_we = psw_we_reg;
   assign psw_wdata = psw_wdata_reg;

   // ==========================================================
   // checks
   wire logic grant = ms_start | vec_start;

   chk_prio_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (|irq_req) |=> !grant [*7])
      else $error("grant inside priority window");

   chk_defer_hold: assert property (@(posedge pclk) disable iff (!presetn)
      defer_event |=> !grant [*8])
      else $error("grant inside deferral window");

   chk_diff_value: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_BUF) && acc_reg.valid |->
      acc_reg.we && acc_reg.wdata == cur_reg - prev_reg)
      else $error("difference value wrong");

   chk_dif_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_BUF) && acc_reg.valid && is_dif |->
      acc_reg.addr == {CH_PAGE, chp_reg} - {msc_reg, 1'b0} - 16'h3)
      else $error("plain differential address wrong");

   chk_difp_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_BUF) && acc_reg.valid && is_difp |->
      acc_reg.addr == mptr_reg - {msc_reg, 1'b0} + 16'h2)
      else $error("pointer differential address wrong");

   chk_count_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_CNT) && acc_done && msc_reg == 8'h1 |=>
      vec_pend_reg[src_reg])
      else $error("count zero raised no request");

   chk_chk_result: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_RES) && acc_reg.valid |->
      (acc_reg.wdata == prev_reg - chk_sub) == chk_ok)
      else $error("check result wrong");

   chk_psw_clear: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_PSWCHK |-> psw_we && psw_wdata == 16'h0)
      else $error("status word not cleared");

   chk_svc_time: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ms_busy) && !unsup_reg |->
      svc_cnt_reg >= svc_target)
      else $error("service ended early");

   chk_susp_req: assert property (@(posedge pclk) disable iff (!presetn)
      grant && long_insn |-> suspend_req ##1 susp_reg)
      else $error("long instruction not suspended");

endmodule // mse_engine

//--- logic/mse_pkg.sv
// Purpose: shared constants, types and layouts of the macro service engine
// Assumes: 16-bit data path, byte addresses, APB register file
// Notes:   offsets, mask and select reset values and cycle counts live here; the checks repeat some as literals
package mse_pkg;

   // ==========================================================
   // apb register offsets and reset values
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_MSEL = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_PEND = 8'h10;
   localparam logic [7:0] OFS_RES = 8'h14;
   localparam logic [15:0] MASK_RST = 16'hFFFF;
   localparam logic [15:0] MSEL_RST = 16'h0000;

   // ==========================================================
   // mode register codes and memory layout
   localparam logic [7:0] MODE_DIF = 8'h99;
   localparam logic [7:0] MODE_DIFP = 8'h9A;
   localparam logic [7:0] MODE_CHK_FULL = 8'hAB;
   localparam logic [7:0] MODE_CHK_RED = 8'h8B;
   localparam logic [15:0] CW_BASE = 16'hFE06;
   localparam logic [7:0] CH_PAGE = 8'hFE;
   localparam logic [7:0] SFR_PAGE = 8'hFF;
   localparam logic [15:0] CH_OFS_CNT = 16'h0001;
   localparam logic [15:0] CH_OFS_PREV = 16'h0003;
   localparam logic [15:0] CH_OFS_MPTR = 16'h0005;
   localparam logic [15:0] DIF_BUF_OFS = 16'h0003;
   localparam logic [15:0] DIFP_BUF_OFS = 16'h0002;
   localparam logic [15:0] PSW_PAT = 16'h5AA5;
   localparam logic [15:0] CHK_FULL_SUB = 16'h000A;
   localparam logic [15:0] CHK_RED_SUB = 16'h0008;

   // ==========================================================
   // cycle counts
   localparam logic [3:0] PRIO_CLKS = 4'h8;
   localparam logic [3:0] DEFER_CLKS = 4'h8;
   localparam logic [7:0] T_VEC_FAST = 8'h1A;    // 26
   localparam logic [7:0] T_VEC_PERIPHERAL_RAM = 8'h1E;    // 30
   localparam logic [7:0] T_VEC_WIDE = 8'h1E;    // 30 + 2n
   localparam logic [7:0] T_VEC_NARROW = 8'h26;  // 38 + 4n
   localparam logic [7:0] T_CTX = 8'h16;         // 22
   localparam logic [7:0] T_SP_ODD = 8'h08;
   localparam logic [7:0] T_DIF = 8'h1C;         // 28
   localparam logic [7:0] T_DIFP = 8'h21;        // 33
   localparam logic [7:0] T_DIFP_SLOW = 8'h23;   // 35
   localparam logic [7:0] T_CHK_FULL = 8'h4E;    // 78
   localparam logic [7:0] T_CHK_RED = 8'h3C;     // 60
   localparam logic [7:0] T_ODD_WORD = 8'h08;
   localparam logic [7:0] T_NARROW_WORD = 8'h04; // plus 2n

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      AREA_FAST = 2'h0, AREA_PERIPHERAL_RAM = 2'h1, AREA_WIDE = 2'h2,
      AREA_NARROW = 2'h3
   } mse_area_e;

   typedef struct packed {
      logic [3:0] wait_n;
      mse_area_e data_area;
      mse_area_e stack_area;
      logic ctx_switch;
      logic enable;
   } mse_ctrl_s;

   typedef struct packed {
      logic valid;
      logic periph;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mse_acc_s;

   typedef enum logic [15:0] {
      ST_IDLE = 16'h0001, ST_CW = 16'h0002, ST_CH = 16'h0004,
      ST_PREV = 16'h0008, ST_MPTR = 16'h0010, ST_SFR = 16'h0020,
      ST_BUF = 16'h0040, ST_SAVE = 16'h0080, ST_CNT = 16'h0100,
      ST_PSW = 16'h0200, ST_PSWCHK = 16'h0400, ST_RAMWR = 16'h0800,
      ST_RAMRD = 16'h1000, ST_RAMRST = 16'h2000, ST_RES = 16'h4000,
      ST_PAD = 16'h8000
   } mse_state_e;

endpackage

//--- dv/mse_mem_model.sv
// Purpose: main ram and peripheral register model behind the engine
// Assumes: one 16-bit word per byte address, bench preloads it
// Notes: slow adds wait cycles; idle read data toggles every cycle
module mse_mem_model
   import mse_pkg::*;
(
   // clock and pace
   input wire logic pclk,
   input wire logic slow,
   // access port
   input wire mse_acc_s acc,
   output logic acc_ack,
   output logic [15:0] acc_rdata
);
   // ==========================================================
   // storage and answer
   logic [15:0] mem [int];
   int w = 0;
   initial acc_ack = 1'h0;
   initial acc_rdata = 16'h0;
   always @(posedge pclk)
   begin
      acc_ack <= 1'h0;
      acc_rdata <= ~acc_rdata;
      if (acc.valid && !acc_ack && w >= (slow ? 3 : 0))
      begin
         acc_ack <= 1'h1;
         w <= 0;
         if (acc.we)
            mem[acc.addr] = acc.wdata;
         else
            acc_rdata <= mem[acc.addr];
      end
      else if (acc.valid)
         w <= w + 1;
   end
endmodule // mse_mem_model

//--- dv/tb_macro_service_engine.sv
// Purpose: self-checking bench of the macro service engine
// Assumes: source 0, channel pointer FE40, peripheral FF12
// Notes: rows cover the four modes; hold count is service time
module tb_macro_service_engine
   import mse_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [7:0] mode, cnt;
      logic [15:0] prev, cur, addr, data, save;
      int hold;
   } mse_row_s;
   mse_row_s rows [5] = '{
      '{MODE_CHK_FULL, 8'h01, 16'h0064, 16'h0, 16'hFF12, 16'h005A,
        16'h0064, 78}, // full check runs first, as at initialisation
      '{MODE_DIF, 8'h02, 16'h1000, 16'h1234, 16'hFE39, 16'h0234, 16'h1234, 28},
      '{MODE_DIF, 8'h01, 16'hFFF0, 16'h0010, 16'hFE3B, 16'h0020, 16'h0010, 28},
      '{MODE_DIFP, 8'h03, 16'h0100, 16'h0050, 16'hFE2C, 16'hFF50,
        16'h0050, 33},
      '{MODE_CHK_RED, 8'h01, 16'h0064, 16'h0, 16'hFF12, 16'h005C,
        16'h0064, 60}};
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
   logic slow = '0, err, pready, pslverr, cpu_hold, psw_we, vec_ack;
   logic vec_busy, acc_ack, suspend_req;
   logic insn_end = 1'h1, defer_event = '0, long_insn = '0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] irq_req = '0, sp_val = 16'h0200, psw_val = '0;
   logic [15:0] acc_rdata, psw_wdata;
   logic [3:0] vec_src;
   mse_acc_s acc;
   int fail_count = 0, comparisons = 0, n, c;
   mse_engine uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
      .insn_end(insn_end), .defer_event(defer_event),
      .long_insn(long_insn), .sp_val(sp_val),
      .psw_val(psw_val), .cpu_hold(cpu_hold), .suspend_req(suspend_req),
      .psw_we(psw_we), .psw_wdata(psw_wdata), .vec_ack(vec_ack),
      .vec_src(vec_src), .vec_busy(vec_busy), .acc(acc), .acc_ack(acc_ack),
      .acc_rdata(acc_rdata));
   mse_mem_model mem_i (.pclk(pclk), .slow(slow), .acc(acc),
      .acc_ack(acc_ack), .acc_rdata(acc_rdata));
   // ==========================================================
   // clock, status word mirror, checking tasks
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk)
      if (psw_we)
         psw_val <= psw_wdata;
   task chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task test_done;
      $display("compares %0d errors %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wt(ref logic s);
      @(negedge pclk);
      for (n = 0; n < 400 && s !== 1'h1; n++) @(negedge pclk);
      if (n == 400)
      begin
         fail_count++;
         test_done;
      end
   endtask
   task automatic len(ref logic s);
      for (c = 0; c < 400 && s === 1'h1; c++) @(negedge pclk);
      if (c == 400)
      begin
         fail_count++;
         test_done;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge pclk);
      if (n == 20)
      begin
         fail_count++;
         test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task ld(input mse_row_s r);
      mem_i.mem[CW_BASE] = {8'h40, r.mode};
      mem_i.mem[16'hFE3F] = {8'h12, r.cnt};
      mem_i.mem[16'hFE3D] = r.prev;
      mem_i.mem[16'hFE3B] = 16'hFE30;
      mem_i.mem[16'hFF12] = r.cur;
      @(posedge pclk);
      irq_req <= 16'h0001;
      @(posedge pclk);
      irq_req <= '0;
   endtask
   task run(input mse_row_s r);
      wt(cpu_hold);
      len(cpu_hold);
      chk("service time", r.hold, c);
      chk("result", r.data, mem_i.mem[r.addr]);
      chk("previous", r.save, mem_i.mem[16'hFE3D]);
      if (r.addr != 16'hFE3B)
         chk("mem pointer", 16'hFE30, mem_i.mem[16'hFE3B]);
      if (r.mode[4])
         chk("count", {8'h12, r.cnt - 8'h01}, mem_i.mem[16'hFE3F]);
      if (r.mode == MODE_CHK_FULL)
         chk("status word", 0, psw_val);
      if (r.mode[4] && r.cnt == 8'h01)
      begin
         wt(vec_busy);
         chk("accept pulse", 1, vec_ack);
         len(vec_busy);
         chk("accept time", 26, c);
         chk("source", 0, vec_src);
      end
   endtask
   // ==========================================================
   // reset, register checks, masked request, rows, fault
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, OFS_MASK, '0);
      chk("mask reset", MASK_RST, rd);
      apb(1'h0, 8'h18, '0);
      chk("unmapped", 1, err);
      apb(1'h1, OFS_CTRL, 32'h1);
      apb(1'h1, OFS_MSEL, 32'h1);
      ld(rows[0]);
      repeat (40) @(negedge pclk);
      chk("masked hold", 0, cpu_hold);
      apb(1'h1, OFS_MASK, 32'hFFFE);
      foreach (rows[i])
      begin
         if (i > 0)
            ld(rows[i]);
         run(rows[i]);
      end
      @(posedge pclk);
      long_insn <= 1'h1;
      insn_end <= 1'h0;
      ld(rows[1]);
      repeat (3) @(posedge pclk);
      defer_event <= 1'h1;
      @(posedge pclk);
      defer_event <= 1'h0;
      wt(suspend_req);
      chk("deferral", DEFER_CLKS, n);
      run(rows[1]);
      @(posedge pclk);
      long_insn <= 1'h0;
      insn_end <= 1'h1;
      slow <= 1'h1;
      ld(rows[4]);
      wt(cpu_hold);
      @(posedge pclk);
      sp_val <= 16'h0202;
      len(cpu_hold);
      chk("fault result", 16'hFFA3, mem_i.mem[16'hFF12]);
      ld(rows[2]);
      wt(cpu_hold);
      @(posedge pclk);
      presetn <= 1'h0;
      @(negedge pclk);
      chk("hold in reset", 0, cpu_hold);
      chk("access in reset", 0, acc.valid);
      @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, OFS_CTRL, '0);
      chk("ctrl after reset", 0, rd);
      test_done;
   end
endmodule // tb_macro_service_engine
